/* logic/core_state_pkg.sv */
// Package for the core architectural state block: data-space map, widths,
// program-counter source codes, flag-mode encoding and stack depth.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
`default_nettype none

package core_state_pkg;

  localparam int DATA_W   = 8;
  localparam int PC_W     = 12;
  localparam int STACK_D  = 6;
  localparam int WIN_LOW  = 6;
  localparam int WBASE_W  = 7;
  localparam int ROM_W    = WBASE_W + WIN_LOW;
  localparam int RAM_D    = 60;
  localparam int RAM_AW   = 6;

  localparam logic [7:0] ADDR_INDEX_ONE  = 8'h80;
  localparam logic [7:0] ADDR_INDEX_TWO  = 8'h81;
  localparam logic [7:0] ADDR_SHORT_ONE  = 8'h82;
  localparam logic [7:0] ADDR_SHORT_TWO  = 8'h83;
  localparam logic [7:0] ADDR_ACCUM      = 8'hFF;
  localparam logic [7:0] ADDR_WIN_BASE   = 8'hC9;
  localparam logic [7:0] ADDR_WIN_FIRST  = 8'h40;
  localparam logic [7:0] ADDR_WIN_LAST   = 8'h7F;
  localparam logic [7:0] ADDR_RAM_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_RAM_LAST   = 8'h3B;

  localparam logic [7:0]      REG_RESET   = 8'h00;
  localparam logic [11:0]     PC_RESET    = 12'h000;
  localparam logic [11:0]     PC_ONE      = 12'h001;
  localparam logic [2:0]      DEPTH_ZERO  = 3'h0;
  localparam logic [2:0]      DEPTH_ONE   = 3'h1;
  localparam logic [2:0]      DEPTH_FULL  = 3'h6;

  // Program counter sources
  typedef enum logic [2:0] {
    PC_INC    = 3'h0,
    PC_JUMP   = 3'h1,
    PC_CALL   = 3'h2,
    PC_REL    = 3'h3,
    PC_VECTOR = 3'h4,
    PC_RET    = 3'h5,
    PC_INTERRUPT_RETURN   = 3'h6,
    PC_HOLD   = 3'h7
  } pc_src_t;

  // Flag modes, one-hot
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b001,
    MODE_IRQ     = 3'b010,
    MODE_NMI     = 3'b100
  } flag_mode_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } flag_pair_t;

  // Flag update request from the ALU
  typedef struct packed {
    logic carry_we;
    logic carry_val;
    logic zero_we;
    logic zero_val;
  } flag_upd_t;

  // Data-space access from the decoder
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } data_req_t;

endpackage : core_state_pkg

`default_nettype wire

/* logic/core_state.sv */
// Architectural state of the 8-bit core: working registers, program counter,
// banked flags, return stack, data RAM and the read-only ROM window.
// Assumes the decoder/ALU drive one step per clock and ROM answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Eight-bit accumulator, also readable and writable at data address FFh.
// - Two pointer registers at data addresses 80h and 81h.
// - Two short-direct registers at data addresses 82h and 83h.
// - Twelve-bit program counter addressing 4096 program bytes.
// - Counter loads target, relative sum, vector, popped value, or increments.
// - Three carry/zero pairs; only the current mode's pair is visible.
// - Interrupt selects irq pair, NMI selects NMI pair, return restores prior.
// - No pair is cleared on a mode switch.
// - Carry follows arithmetic carry, bit test value, feeds rotate left.
// - Zero is set when the latest result is zero.
// - Reset enters NMI mode, using the NMI pair first.
// - Six-entry twelve-bit hardware return stack, no visible pointer.
// - Call or interrupt shifts entries down and pushes the counter.
// - Return loads counter from level one and shifts entries up.
// - More than six nestings keep depth at six, losing the oldest.
// - Return on empty stack keeps depth and continues with next instruction.
// - Data 40h..7Fh is a 64-byte ROM window relocatable in 64-byte steps.
// - Bank switch extends program space beyond the counter's 4K.
// - Data space holds 60 bytes of RAM plus core registers.
// - Eight-bit direct data addresses; no data bank switch register.
// - Window ROM address is base register above six operand bits.
// - Window base is write-only and not cleared by reset.
module core_state #(
  parameter int STACK_DEPTH = core_state_pkg::STACK_D,
  parameter int RAM_WORDS   = core_state_pkg::RAM_D,
  parameter int BANK_W      = 1
) (
  input  wire logic                              sys_clk,         // Core clock
  input  wire logic                              reset_n,         // Synchronous reset, low
  input  wire core_state_pkg::pc_src_t           pc_src,          // Program counter source
  input  wire logic [core_state_pkg::PC_W-1:0]   pc_target,       // Jump/call target or vector
  input  wire logic [core_state_pkg::DATA_W-1:0] rel_offset,      // Signed relative offset
  input  wire logic                              irq_enter,       // Maskable interrupt accepted
  input  wire logic                              nmi_enter,       // Non-maskable accepted
  input  wire core_state_pkg::flag_upd_t         flag_upd,        // Flag writes from ALU
  input  wire logic                              accum_we,        // ALU result to accumulator
  input  wire logic [core_state_pkg::DATA_W-1:0] accum_wdata,     // ALU result
  input  wire core_state_pkg::data_req_t         data_req,        // Data-space access
  input  wire logic [BANK_W-1:0]                 bank_sel,        // Program bank from switch reg
  input  wire logic [core_state_pkg::DATA_W-1:0] rom_rdata,       // ROM byte at rom_addr
  input  wire logic [core_state_pkg::DATA_W-1:0] periph_rdata,    // Peripheral read data
  output logic [core_state_pkg::PC_W-1:0]        program_counter, // Next program byte address
  output logic [BANK_W-1:0]                      prog_bank,       // Program bank for fetch
  output logic [core_state_pkg::ROM_W-1:0]       rom_addr,        // ROM address, fetch or window
  output logic                                   rom_win_sel,     // ROM read is a window read
  output logic [core_state_pkg::DATA_W-1:0]      data_rdata,      // Data-space read result
  output logic                                   periph_sel,      // Access goes to peripherals
  output logic [core_state_pkg::DATA_W-1:0]      accumulator,     // Accumulator contents
  output logic                                   carry_flag,      // Active carry
  output logic                                   zero_flag,       // Active zero
  output core_state_pkg::flag_mode_t             flag_mode,       // Current flag mode
  output logic [2:0]                             stack_depth      // Entries held
);

  logic [7:0]  index_pointer_one;
  logic [7:0]  index_pointer_two;
  logic [7:0]  short_direct_one;
  logic [7:0]  short_direct_two;
  logic [core_state_pkg::WBASE_W-1:0] rom_window_base_reg;
  logic [7:0]  ram [RAM_WORDS];
  logic [core_state_pkg::PC_W-1:0] stack_mem [STACK_DEPTH];
  core_state_pkg::flag_pair_t carry_zero_normal;
  core_state_pkg::flag_pair_t carry_zero_irq;
  core_state_pkg::flag_pair_t carry_zero_nmi;
  core_state_pkg::flag_mode_t saved_mode [STACK_DEPTH];
  core_state_pkg::flag_mode_t next_mode;
  logic [core_state_pkg::PC_W-1:0] next_pc;
  logic        push;
  logic        pop;
  logic        win_hit;
  logic        ram_hit;
  logic        is_return;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic data_write(input core_state_pkg::data_req_t r, input logic [7:0] a);
    data_write = r.wr && (r.addr == a);
  endfunction

  assign push      = (pc_src == core_state_pkg::PC_CALL) || irq_enter || nmi_enter;
  assign is_return = (pc_src == core_state_pkg::PC_RET) || (pc_src == core_state_pkg::PC_INTERRUPT_RETURN);
  assign pop       = is_return && (stack_depth != core_state_pkg::DEPTH_ZERO);
  assign win_hit   = in_range(data_req.addr, core_state_pkg::ADDR_WIN_FIRST,
                              core_state_pkg::ADDR_WIN_LAST);
  assign ram_hit   = in_range(data_req.addr, core_state_pkg::ADDR_RAM_FIRST,
                              core_state_pkg::ADDR_RAM_LAST);

  // Program counter source selection
  always_comb begin
    case (pc_src)
      core_state_pkg::PC_JUMP,
      core_state_pkg::PC_CALL,
      core_state_pkg::PC_VECTOR: next_pc = pc_target;
      core_state_pkg::PC_REL:    next_pc = program_counter +
                                   {{(core_state_pkg::PC_W-8){rel_offset[7]}}, rel_offset};
      core_state_pkg::PC_RET,
      core_state_pkg::PC_INTERRUPT_RETURN:   next_pc = pop ? stack_mem[0] : program_counter + core_state_pkg::PC_ONE;
      core_state_pkg::PC_HOLD:   next_pc = program_counter;
      default:                   next_pc = program_counter + core_state_pkg::PC_ONE;
    endcase
    if (irq_enter || nmi_enter) begin
      next_pc = pc_target;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      program_counter <= core_state_pkg::PC_RESET;
    end else begin
      program_counter <= next_pc;
    end
  end

  // Return stack: push shifts deeper, pop shifts toward the top
  always_ff @(posedge sys_clk) begin
    if (push) begin
      stack_mem[0] <= program_counter;
      saved_mode[0] <= flag_mode;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack_mem[i]  <= stack_mem[i-1];
        saved_mode[i] <= saved_mode[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH-1; i++) begin
        stack_mem[i]  <= stack_mem[i+1];
        saved_mode[i] <= saved_mode[i+1];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stack_depth <= core_state_pkg::DEPTH_ZERO;
    end else if (push) begin
      // Push wins over a same-cycle pop, so a full stack must not lose depth here
      if (stack_depth != core_state_pkg::DEPTH_FULL) begin
        stack_depth <= stack_depth + core_state_pkg::DEPTH_ONE;
      end
    end else if (pop) begin
      stack_depth <= stack_depth - core_state_pkg::DEPTH_ONE;
    end
  end

  // Flag mode switching
  always_comb begin
    next_mode = flag_mode;
    if (nmi_enter) begin
      next_mode = core_state_pkg::MODE_NMI;
    end else if (irq_enter) begin
      next_mode = core_state_pkg::MODE_IRQ;
    end else if (pc_src == core_state_pkg::PC_INTERRUPT_RETURN) begin
      next_mode = pop ? saved_mode[0] : core_state_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flag_mode <= core_state_pkg::MODE_NMI;
    end else begin
      flag_mode <= next_mode;
    end
  end

  // Each pair updates only in its own mode and is never cleared on a switch
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      carry_zero_normal <= '0;
      carry_zero_irq    <= '0;
      carry_zero_nmi    <= '0;
    end else begin
      case (flag_mode)
        core_state_pkg::MODE_NORMAL: begin
          if (flag_upd.carry_we) carry_zero_normal.carry <= flag_upd.carry_val;
          if (flag_upd.zero_we)  carry_zero_normal.zero  <= flag_upd.zero_val;
        end
        core_state_pkg::MODE_IRQ: begin
          if (flag_upd.carry_we) carry_zero_irq.carry <= flag_upd.carry_val;
          if (flag_upd.zero_we)  carry_zero_irq.zero  <= flag_upd.zero_val;
        end
        default: begin
          if (flag_upd.carry_we) carry_zero_nmi.carry <= flag_upd.carry_val;
          if (flag_upd.zero_we)  carry_zero_nmi.zero  <= flag_upd.zero_val;
        end
      endcase
    end
  end

  always_comb begin
    case (flag_mode)
      core_state_pkg::MODE_NORMAL: {carry_flag, zero_flag} = carry_zero_normal;
      core_state_pkg::MODE_IRQ:    {carry_flag, zero_flag} = carry_zero_irq;
      default:                     {carry_flag, zero_flag} = carry_zero_nmi;
    endcase
  end

  // Working registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      accumulator <= core_state_pkg::REG_RESET;
    end else if (data_write(data_req, core_state_pkg::ADDR_ACCUM)) begin
      accumulator <= data_req.wdata;
    end else if (accum_we) begin
      accumulator <= accum_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      index_pointer_one <= core_state_pkg::REG_RESET;
      index_pointer_two <= core_state_pkg::REG_RESET;
    end else begin
      if (data_write(data_req, core_state_pkg::ADDR_INDEX_ONE)) index_pointer_one <= data_req.wdata;
      if (data_write(data_req, core_state_pkg::ADDR_INDEX_TWO)) index_pointer_two <= data_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      short_direct_one <= core_state_pkg::REG_RESET;
      short_direct_two <= core_state_pkg::REG_RESET;
    end else begin
      if (data_write(data_req, core_state_pkg::ADDR_SHORT_ONE)) short_direct_one <= data_req.wdata;
      if (data_write(data_req, core_state_pkg::ADDR_SHORT_TWO)) short_direct_two <= data_req.wdata;
    end
  end

  // Window base survives reset
  always_ff @(posedge sys_clk) begin
    if (data_write(data_req, core_state_pkg::ADDR_WIN_BASE)) begin
      rom_window_base_reg <= data_req.wdata[core_state_pkg::WBASE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (data_req.wr && ram_hit) begin
      ram[data_req.addr[core_state_pkg::RAM_AW-1:0]] <= data_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prog_bank <= '0;
    end else begin
      prog_bank <= bank_sel;
    end
  end

  // ROM address: window read or instruction fetch
  always_comb begin
    rom_win_sel = data_req.rd && win_hit;
    if (rom_win_sel) begin
      rom_addr = {rom_window_base_reg, data_req.addr[core_state_pkg::WIN_LOW-1:0]};
    end else begin
      rom_addr = {{(core_state_pkg::ROM_W-core_state_pkg::PC_W){1'b0}}, program_counter};
    end
  end

  // Eight-bit direct decode; the window base reads as zero, not as peripheral space
  always_comb begin
    periph_sel = 1'b0;
    if (data_req.addr == core_state_pkg::ADDR_ACCUM) begin
      data_rdata = accumulator;
    end else if (data_req.addr == core_state_pkg::ADDR_INDEX_ONE) begin
      data_rdata = index_pointer_one;
    end else if (data_req.addr == core_state_pkg::ADDR_INDEX_TWO) begin
      data_rdata = index_pointer_two;
    end else if (data_req.addr == core_state_pkg::ADDR_SHORT_ONE) begin
      data_rdata = short_direct_one;
    end else if (data_req.addr == core_state_pkg::ADDR_SHORT_TWO) begin
      data_rdata = short_direct_two;
    end else if (win_hit) begin
      data_rdata = rom_rdata;
    end else if (ram_hit) begin
      data_rdata = ram[data_req.addr[core_state_pkg::RAM_AW-1:0]];
    end else if (data_req.addr == core_state_pkg::ADDR_WIN_BASE) begin
      data_rdata = core_state_pkg::REG_RESET;
    end else begin
      periph_sel = data_req.rd || data_req.wr;
      data_rdata = periph_rdata;
    end
  end

  // Checks
  a_reset_nmi_mode: assert property (@(posedge sys_clk) !reset_n |=> flag_mode == core_state_pkg::MODE_NMI)
    else $error("mode after reset is not NMI");
  a_pc_increment: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pc_src == core_state_pkg::PC_INC && !irq_enter && !nmi_enter)
    |=> program_counter == $past(program_counter) + core_state_pkg::PC_ONE)
    else $error("counter did not increment");
  a_pc_jump_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pc_src == core_state_pkg::PC_JUMP) |=> program_counter == $past(pc_target))
    else $error("jump target not loaded");
  a_call_return_pair: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pc_src == core_state_pkg::PC_CALL && !irq_enter && !nmi_enter) ##1
    (pc_src == core_state_pkg::PC_RET && !push) |=> program_counter == $past(program_counter, 2))
    else $error("return address mismatch");
  a_push_stores_pc: assert property (@(posedge sys_clk) disable iff (!reset_n)
    push |=> stack_mem[0] == $past(program_counter))
    else $error("push did not store counter");
  a_depth_saturate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    stack_depth <= core_state_pkg::DEPTH_FULL)
    else $error("stack depth above six");
  a_full_push_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (push && stack_depth == core_state_pkg::DEPTH_FULL) |=> stack_depth == core_state_pkg::DEPTH_FULL)
    else $error("full stack lost depth on push");
  a_empty_return: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (is_return && stack_depth == core_state_pkg::DEPTH_ZERO && !push)
    |=> stack_depth == core_state_pkg::DEPTH_ZERO
        && program_counter == $past(program_counter) + core_state_pkg::PC_ONE)
    else $error("empty return misbehaved");
  a_irq_mode_switch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (irq_enter && !nmi_enter) |=> flag_mode == core_state_pkg::MODE_IRQ)
    else $error("irq pair not selected");
  a_nmi_mode_switch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    nmi_enter |=> flag_mode == core_state_pkg::MODE_NMI)
    else $error("nmi pair not selected");
  a_pair_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (flag_mode != core_state_pkg::MODE_NORMAL) |=> carry_zero_normal == $past(carry_zero_normal))
    else $error("normal pair changed outside normal mode");
  a_window_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rom_win_sel |-> rom_addr[core_state_pkg::WIN_LOW-1:0] == data_req.addr[core_state_pkg::WIN_LOW-1:0])
    else $error("window address wrong");
  a_accum_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    data_write(data_req, core_state_pkg::ADDR_ACCUM) |=> accumulator == $past(data_req.wdata))
    else $error("accumulator write lost");

  c_nested_full: cover property (@(posedge sys_clk) disable iff (!reset_n)
    push && stack_depth == core_state_pkg::DEPTH_FULL);
  c_interrupt_return_normal: cover property (@(posedge sys_clk) disable iff (!reset_n)
    flag_mode == core_state_pkg::MODE_IRQ ##1 flag_mode == core_state_pkg::MODE_NORMAL);
  c_window_read: cover property (@(posedge sys_clk) disable iff (!reset_n) rom_win_sel);
  c_empty_return: cover property (@(posedge sys_clk) disable iff (!reset_n)
    is_return && stack_depth == core_state_pkg::DEPTH_ZERO);

endmodule : core_state

`default_nettype wire

/* test/rom_periph_model.sv */
// Behavioural program ROM and peripheral read port facing core_state.
// Assumes the core presents rom_addr and periph_sel combinationally.
`timescale 1ns/1ps
`default_nettype none
module rom_periph_model (
  input  wire logic [12:0] rom_addr,     // Byte address into program ROM
  input  wire logic        periph_sel,   // Peripheral access selected
  output logic [7:0]       rom_rdata,    // ROM byte, same cycle
  output logic [7:0]       periph_rdata  // Peripheral byte, same cycle
);
  // Content depends on both base and offset bits, so a wrong window address shows
  assign rom_rdata    = rom_addr[7:0] ^ 8'h3C ^ {3'h0, rom_addr[12:8]};
  // Deselected peripherals show the inverse pattern, never a held value
  assign periph_rdata = periph_sel ? 8'hA5 : 8'h5A;
endmodule // rom_periph_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for core_state: reset, flags, data space, window, counter, stack.
// Assumes core_state_pkg, core_state and rom_periph_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                      sys_clk     = 1'b0;
  logic                      reset_n     = 1'b0;
  core_state_pkg::pc_src_t   pc_src      = core_state_pkg::PC_HOLD;
  logic [11:0]               pc_target   = 12'h000;
  logic [7:0]                rel_offset  = 8'h00;
  logic                      irq_enter   = 1'b0;
  logic                      nmi_enter   = 1'b0;
  core_state_pkg::flag_upd_t flag_upd    = '0;
  logic                      accum_we    = 1'b0;
  logic [7:0]                accum_wdata = 8'h00;
  core_state_pkg::data_req_t data_req    = '0;
  logic [0:0]                bank_sel    = 1'b0;
  wire logic [7:0]           rom_rdata, periph_rdata, data_rdata, accumulator;
  wire logic [11:0]          program_counter;
  wire logic [0:0]           prog_bank;
  wire logic [12:0]          rom_addr;
  wire logic                 rom_win_sel, periph_sel, carry_flag, zero_flag;
  wire logic [2:0]           flag_mode, stack_depth;
  int                        errors = 0;
  int                        checks_done = 0;
  int                        cycles = 0;
  logic [7:0]                reg_addrs [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h00, 8'h3B};

  core_state DUT (.sys_clk(sys_clk), .reset_n(reset_n), .pc_src(pc_src), .pc_target(pc_target),
    .rel_offset(rel_offset), .irq_enter(irq_enter), .nmi_enter(nmi_enter), .flag_upd(flag_upd),
    .accum_we(accum_we), .accum_wdata(accum_wdata), .data_req(data_req), .bank_sel(bank_sel),
    .rom_rdata(rom_rdata), .periph_rdata(periph_rdata), .program_counter(program_counter),
    .prog_bank(prog_bank), .rom_addr(rom_addr), .rom_win_sel(rom_win_sel), .data_rdata(data_rdata),
    .periph_sel(periph_sel), .accumulator(accumulator), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .flag_mode(flag_mode), .stack_depth(stack_depth));
  rom_periph_model partner (.rom_addr(rom_addr), .periph_sel(periph_sel), .rom_rdata(rom_rdata),
    .periph_rdata(periph_rdata));

  always #12.5 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic drive(input core_state_pkg::pc_src_t s, input logic [11:0] t, input logic [3:0] fu,
                       input logic irq, input logic nmi);
    pc_src    = s;
    pc_target = t;
    flag_upd  = core_state_pkg::flag_upd_t'(fu);
    irq_enter = irq;
    nmi_enter = nmi;
    cyc();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    data_req = '{1'b0, 1'b1, a, d};
    cyc();
  endtask

  task automatic rd(input logic [7:0] a);
    data_req = '{1'b1, 1'b0, a, 8'h00};
    cyc();
  endtask

  task automatic flags_and_modes();
    check("mode", {13'h0, flag_mode}, {13'h0, core_state_pkg::MODE_NMI});
    drive(core_state_pkg::PC_HOLD, 12'h000, 4'b1100, 1'b0, 1'b0);
    check("carry", {15'h0, carry_flag}, 16'h0001);
    drive(core_state_pkg::PC_INTERRUPT_RETURN, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("mode", {13'h0, flag_mode}, {13'h0, core_state_pkg::MODE_NORMAL});
    check("flags", {14'h0, carry_flag, zero_flag}, 16'h0000);
    drive(core_state_pkg::PC_HOLD, 12'h000, 4'b0011, 1'b0, 1'b0);
    check("zero", {15'h0, zero_flag}, 16'h0001);
    drive(core_state_pkg::PC_HOLD, 12'hFF6, 4'b0000, 1'b1, 1'b0);
    check("mode", {13'h0, flag_mode}, {13'h0, core_state_pkg::MODE_IRQ});
    check("flags", {14'h0, carry_flag, zero_flag}, 16'h0000);
    check("counter", {4'h0, program_counter}, 16'h0FF6);
    drive(core_state_pkg::PC_HOLD, 12'h000, 4'b1100, 1'b0, 1'b0);
    drive(core_state_pkg::PC_HOLD, 12'hFFC, 4'b0000, 1'b0, 1'b1);
    check("flags", {14'h0, carry_flag, zero_flag}, 16'h0002);
    check("depth", {13'h0, stack_depth}, 16'h0002);
    drive(core_state_pkg::PC_INTERRUPT_RETURN, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("mode", {13'h0, flag_mode}, {13'h0, core_state_pkg::MODE_IRQ});
    check("flags", {14'h0, carry_flag, zero_flag}, 16'h0002);
    drive(core_state_pkg::PC_INTERRUPT_RETURN, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("flags", {14'h0, carry_flag, zero_flag}, 16'h0001);
    drive(core_state_pkg::PC_HOLD, 12'h000, 4'b0000, 1'b0, 1'b0);
    $display("test flags_and_modes done");
  endtask

  task automatic data_space();
    for (int i = 0; i < 7; i++) wr(reg_addrs[i], reg_addrs[i] ^ 8'h5A);
    for (int i = 0; i < 7; i++) begin
      rd(reg_addrs[i]);
      check("data", {8'h0, data_rdata}, {8'h0, reg_addrs[i] ^ 8'h5A});
    end
    check("accumulator", {8'h0, accumulator}, 16'h00A5);
    accum_we    = 1'b1;
    accum_wdata = 8'h3E;
    cyc();
    accum_we = 1'b0;
    check("accumulator", {8'h0, accumulator}, 16'h003E);
    rd(8'h84);
    check("periph", {7'h0, periph_sel, data_rdata}, 16'h01A5);
    $display("test data_space done");
  endtask

  task automatic rom_window();
    wr(core_state_pkg::ADDR_WIN_BASE, 8'h05);
    wr(8'h45, 8'hFF);
    rd(core_state_pkg::ADDR_WIN_BASE);
    check("base read", {8'h0, data_rdata}, 16'h0000);
    rd(8'h40);
    check("win addr", {2'h0, rom_win_sel, rom_addr}, 16'h2140);
    check("win data", {8'h0, data_rdata}, 16'h007D);
    rd(8'h7F);
    check("win addr", {2'h0, rom_win_sel, rom_addr}, 16'h217F);
    rd(8'h45);
    check("win data", {8'h0, data_rdata}, 16'h0078);
    // Mid-run reset must leave the window base in place and re-enter NMI mode
    reset_n = 1'b0;
    cyc();
    reset_n = 1'b1;
    rd(8'h40);
    check("win kept", {8'h0, data_rdata}, 16'h007D);
    check("mode", {13'h0, flag_mode}, {13'h0, core_state_pkg::MODE_NMI});
    data_req = '0;
    $display("test rom_window done");
  endtask

  task automatic counter_moves();
    bank_sel   = 1'b1;
    drive(core_state_pkg::PC_JUMP, 12'h3F0, 4'b0000, 1'b0, 1'b0);
    check("counter", {4'h0, program_counter}, 16'h03F0);
    check("fetch", {3'h0, rom_addr}, 16'h03F0);
    check("bank", {15'h0, prog_bank}, 16'h0001);
    rel_offset = 8'h10;
    drive(core_state_pkg::PC_REL, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("counter", {4'h0, program_counter}, 16'h0400);
    rel_offset = 8'hF0;
    drive(core_state_pkg::PC_REL, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("counter", {4'h0, program_counter}, 16'h03F0);
    drive(core_state_pkg::PC_VECTOR, 12'hFFF, 4'b0000, 1'b0, 1'b0);
    drive(core_state_pkg::PC_INC, 12'h000, 4'b0000, 1'b0, 1'b0);
    check("counter", {4'h0, program_counter}, 16'h0000);
    $display("test counter_moves done");
  endtask

  task automatic stack_depths();
    drive(core_state_pkg::PC_JUMP, 12'h100, 4'b0000, 1'b0, 1'b0);
    for (int i = 1; i <= 7; i++) begin
      drive(core_state_pkg::PC_CALL, 12'h200 + 12'(i), 4'b0000, 1'b0, 1'b0);
      check("depth", {13'h0, stack_depth}, (i > 6) ? 16'h0006 : 16'(i));
    end
    for (int k = 1; k <= 7; k++) begin
      drive(core_state_pkg::PC_RET, 12'h000, 4'b0000, 1'b0, 1'b0);
      check("counter", {4'h0, program_counter}, (k > 6) ? 16'h0202 : 16'h0200 + 16'(7 - k));
      check("depth", {13'h0, stack_depth}, (k > 6) ? 16'h0000 : 16'(6 - k));
    end
    drive(core_state_pkg::PC_HOLD, 12'h000, 4'b0000, 1'b0, 1'b0);
    $display("test stack_depths done");
  endtask

  initial begin
    repeat (4) cyc();
    reset_n = 1'b1;
    check("counter", {4'h0, program_counter}, 16'h0000);
    check("depth", {13'h0, stack_depth}, 16'h0000);
    flags_and_modes();
    data_space();
    rom_window();
    counter_moves();
    stack_depths();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
